// [hw/aife_code_if.sv]
/*
  aife_code_if: carries the chosen code and class between encoder and top.
  assumes one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
interface aife_code_if;
  logic [15:0] code;
  aife_pkg::aife_sev_e sev;
  modport enc (output code, output sev);
  modport use_side (input code, input sev);
endinterface : aife_code_if
`default_nettype wire

// [hw/aife_pkg.sv]
/*
  aife_pkg: constants for the analog input fault code encoder.
  assumes a classic wishbone slave with 32-bit data, byte addresses.
*/
package aife_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CONFIG = 8'h00;
  localparam logic [7:0] OFF_LAMPCFG = 8'h04;
  localparam logic [7:0] OFF_FLAGS = 8'h08;
  localparam logic [7:0] OFF_CODE = 8'h0C;
  localparam logic [7:0] OFF_IRQSTAT = 8'h10;
  localparam logic [7:0] OFF_IRQMASK = 8'h14;
  localparam logic [7:0] OFF_LAMPS = 8'h18;
  // reset values
  localparam logic [15:0] CONFIG_RST = 16'h0000;
  localparam logic [7:0] LAMPCFG_RST = 8'h00;
  localparam logic [2:0] IRQMASK_RST = 3'h0;
  // fault codes
  localparam logic [15:0] CODE_NONE = 16'h0000;
  localparam logic [15:0] CODE_HW_FAIL = 16'hA600;
  localparam logic [15:0] CODE_SUPPLY = 16'hA601;
  localparam logic [15:0] CODE_CALIB = 16'hA603;
  localparam logic [15:0] CODE_CH_ALARM = 16'hA400;
  localparam logic [15:0] CODE_CH_BLINK = 16'hA000;
  localparam logic [15:0] CODE_CH_QUIET = 16'hA800;
  // field positions
  localparam int CFG_ALARM_LSB = 8;
  localparam int FLAG_SUPPLY_BIT = 15;
  // irq status bits
  localparam int IRQ_ALARM = 0;
  localparam int IRQ_WARN = 1;
  localparam int IRQ_CODE_CHG = 2;
  // blink half period: 250 ms at 100 MHz
  localparam int BLINK_HALF_MS = 250;
  localparam int CLK_MHZ = 100;
  localparam int BLINK_HALF_CYC = BLINK_HALF_MS * 1000 * CLK_MHZ;
  // severity classes
  typedef enum logic [3:0] {
    SEV_NONE = 4'b0001,
    SEV_QUIET = 4'b0010,
    SEV_BLINK = 4'b0100,
    SEV_ALARM = 4'b1000
  } aife_sev_e;
endpackage : aife_pkg

// [hw/aife_prio_enc.sv]
/*
  aife_prio_enc: combinational priority choice of the reported fault code.
  assumes all inputs are registered in the caller.
*/
`timescale 1ns/10ps
`default_nettype none
module aife_prio_enc #(
  parameter int NCH = 8
) (
  // faults
  input wire logic hwFail,
  input wire logic supplyBad,
  input wire logic calibBad,
  input wire logic [NCH-1:0] rangeFlags,
  // per-channel config
  input wire logic [NCH-1:0] alarmSel,
  input wire logic [NCH-1:0] blinkSel,
  // result
  aife_code_if.enc res
);
  // lowest set channel, or none
  function automatic logic [4:0] lowestSet(input logic [NCH-1:0] v);
    logic [4:0] r;
    r = 5'h10;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  logic [NCH-1:0] alm;
  logic [NCH-1:0] blk;
  logic [NCH-1:0] qui;
  logic [4:0] ch;

  always_comb begin
    alm = rangeFlags & alarmSel;
    blk = rangeFlags & ~alarmSel & blinkSel;
    qui = rangeFlags & ~alarmSel & ~blinkSel;
    ch = 5'h0;
    res.code = aife_pkg::CODE_NONE;
    res.sev = aife_pkg::SEV_NONE;
    if (hwFail) begin
      res.code = aife_pkg::CODE_HW_FAIL;
      res.sev = aife_pkg::SEV_ALARM;
    end else if (supplyBad) begin
      res.code = aife_pkg::CODE_SUPPLY;
      res.sev = aife_pkg::SEV_ALARM;
    end else if (calibBad) begin
      res.code = aife_pkg::CODE_CALIB;
      res.sev = aife_pkg::SEV_ALARM;
    end else if (|alm) begin
      ch = lowestSet(alm);
      res.code = aife_pkg::CODE_CH_ALARM | {12'h000, ch[3:0]};
      res.sev = aife_pkg::SEV_ALARM;
    end else if (|blk) begin
      ch = lowestSet(blk);
      res.code = aife_pkg::CODE_CH_BLINK | {12'h000, ch[3:0]};
      res.sev = aife_pkg::SEV_BLINK;
    end else if (|qui) begin
      ch = lowestSet(qui);
      res.code = aife_pkg::CODE_CH_QUIET | {12'h000, ch[3:0]};
      res.sev = aife_pkg::SEV_QUIET;
    end
  end
endmodule : aife_prio_enc
`default_nettype wire

// [hw/aife_top.sv]
/*
  aife_top: fault code encoder and lamp driver with a wishbone slave.
  assumes fault inputs synchronous to mclk, classic wishbone master.
*/
// The register offsets and register access over Wishbone were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module aife_top #(
  parameter int NCH = 8,
  parameter int BLINK_HALF = aife_pkg::BLINK_HALF_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  input wire logic clkEn,
  // fault sources
  input wire logic hwFail,
  input wire logic calibBad,
  input wire logic supplyBad,
  input wire logic [NCH-1:0] rangeFault,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // indicators
  output logic runLamp,
  output logic errLamp,
  output logic [15:0] faultCode,
  output logic irq
);
  logic [15:0] config_q, config_d;
  logic [7:0] lampCfg_q, lampCfg_d;
  logic [15:0] flags_q, flags_d;
  logic hwFail_q, hwFail_d, calib_q, calib_d;
  logic [2:0] irqStat_q, irqStat_d, irqMask_q, irqMask_d;
  logic [31:0] dat_q, dat_d;
  logic ack_q, ack_d;
  logic [15:0] code_q, code_d;
  logic run_q, run_d, err_q, err_d, irq_q, irq_d;
  logic [31:0] blinkCnt_q, blinkCnt_d;
  logic blinkPh_q, blinkPh_d;
  logic req, wr;
  logic [2:0] ev;

  aife_code_if cif ();

  aife_prio_enc #(.NCH(NCH)) u_enc (
    .hwFail(hwFail_q),
    .supplyBad(flags_q[aife_pkg::FLAG_SUPPLY_BIT]),
    .calibBad(calib_q),
    .rangeFlags(flags_q[NCH-1:0]),
    .alarmSel(config_q[aife_pkg::CFG_ALARM_LSB +: NCH]),
    .blinkSel(lampCfg_q[NCH-1:0]),
    .res(cif.enc)
  );

  // byte-lane write merge
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    logic [15:0] r;
    r = old;
    if (s[0]) begin
      r[7:0] = d[7:0];
    end
    if (s[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  always_comb begin
    req = wb_cyc_i & wb_stb_i & ~ack_q;
    wr = req & wb_we_i;
    config_d = config_q;
    lampCfg_d = lampCfg_q;
    irqMask_d = irqMask_q;
    dat_d = dat_q;
    ack_d = req;
    flags_d = '0;
    flags_d[NCH-1:0] = rangeFault;
    flags_d[aife_pkg::FLAG_SUPPLY_BIT] = supplyBad;
    hwFail_d = hwFail;
    calib_d = calibBad;
    code_d = cif.code;
    ev[aife_pkg::IRQ_ALARM] = (cif.sev == aife_pkg::SEV_ALARM);
    ev[aife_pkg::IRQ_WARN] = (cif.sev == aife_pkg::SEV_BLINK) ||
                             (cif.sev == aife_pkg::SEV_QUIET);
    ev[aife_pkg::IRQ_CODE_CHG] = (cif.code != code_q);
    irqStat_d = irqStat_q;
    if (req) begin
      if (wb_adr_i == aife_pkg::OFF_CONFIG) begin
        if (wr) config_d = merge16(config_q, wb_dat_i, wb_sel_i);
        dat_d = {16'h0000, config_q};
      end else if (wb_adr_i == aife_pkg::OFF_LAMPCFG) begin
        if (wr && wb_sel_i[0]) lampCfg_d = wb_dat_i[7:0];
        dat_d = {24'h00_0000, lampCfg_q};
      end else if (wb_adr_i == aife_pkg::OFF_FLAGS) begin
        dat_d = {16'h0000, flags_q};
      end else if (wb_adr_i == aife_pkg::OFF_CODE) begin
        dat_d = {16'h0000, code_q};
      end else if (wb_adr_i == aife_pkg::OFF_IRQSTAT) begin
        if (wr && wb_sel_i[0]) irqStat_d = irqStat_q & ~wb_dat_i[2:0];
        dat_d = {29'h000_0000, irqStat_q};
      end else if (wb_adr_i == aife_pkg::OFF_IRQMASK) begin
        if (wr && wb_sel_i[0]) irqMask_d = wb_dat_i[2:0];
        dat_d = {29'h000_0000, irqMask_q};
      end else if (wb_adr_i == aife_pkg::OFF_LAMPS) begin
        dat_d = {30'h000_0000, run_q, err_q};
      end else begin
        // unmapped: ack with zero
        dat_d = 32'h0000_0000;
      end
    end
    // set wins over a same-cycle clear
    irqStat_d = irqStat_d | ev;
    irq_d = |(irqStat_d & irqMask_d);
    // blink timebase
    blinkCnt_d = blinkCnt_q + 32'h0000_0001;
    blinkPh_d = blinkPh_q;
    if (blinkCnt_q >= 32'(BLINK_HALF - 1)) begin
      blinkCnt_d = 32'h0000_0000;
      blinkPh_d = ~blinkPh_q;
    end
    run_d = 1'b1;
    err_d = 1'b0;
    case (cif.sev)
      aife_pkg::SEV_ALARM: begin
        run_d = 1'b0;
        err_d = 1'b1;
      end
      aife_pkg::SEV_BLINK: begin
        err_d = blinkPh_q;
      end
      aife_pkg::SEV_QUIET: begin
        err_d = 1'b0;
      end
      default: begin
        err_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      config_q <= aife_pkg::CONFIG_RST;
      lampCfg_q <= aife_pkg::LAMPCFG_RST;
      irqMask_q <= aife_pkg::IRQMASK_RST;
      flags_q <= 16'h0000;
      hwFail_q <= 1'b0;
      calib_q <= 1'b0;
      irqStat_q <= 3'h0;
      dat_q <= 32'h0000_0000;
      ack_q <= 1'b0;
      code_q <= aife_pkg::CODE_NONE;
      run_q <= 1'b0;
      err_q <= 1'b0;
      irq_q <= 1'b0;
      blinkCnt_q <= 32'h0000_0000;
      blinkPh_q <= 1'b0;
    end else if (clkEn) begin
      config_q <= config_d;
      lampCfg_q <= lampCfg_d;
      irqMask_q <= irqMask_d;
      flags_q <= flags_d;
      hwFail_q <= hwFail_d;
      calib_q <= calib_d;
      irqStat_q <= irqStat_d;
      dat_q <= dat_d;
      ack_q <= ack_d;
      code_q <= code_d;
      run_q <= run_d;
      err_q <= err_d;
      irq_q <= irq_d;
      blinkCnt_q <= blinkCnt_d;
      blinkPh_q <= blinkPh_d;
    end
  end

  assign wb_dat_o = dat_q;
  assign wb_ack_o = ack_q;
  assign runLamp = run_q;
  assign errLamp = err_q;
  assign faultCode = code_q;
  assign irq = irq_q;
endmodule : aife_top
`default_nettype wire

// [verification/aife_host.sv]
/* aife_host: host controller model, a classic wishbone master.
   assumes the slave acks every request. */
`timescale 1ns/10ps
`default_nettype none
module aife_host (
  // clock
  input wire logic mclk,
  // request
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [7:0] adr,
  output logic [3:0] sel,
  output logic [31:0] dout,
  // answer
  input wire logic [31:0] din,
  input wire logic ack
);
  initial {cyc, stb, we, adr, sel, dout} = '0;
  // held until ack is seen, then one idle cycle at least
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge mclk);
    {cyc, stb, we, adr, sel, dout} <= {1'b1, 1'b1, w, a, 4'hF, d};
    do @(posedge mclk); while (ack !== 1'b1);
    q = din;
    {cyc, stb} <= 2'b00;
  endtask
endmodule : aife_host
`default_nettype wire

// [verification/aife_top_props.sv]
/* aife_top_props: port checker for aife_top.
   assumes one clock; fault inputs held steady while clkEn is low. */
`timescale 1ns/10ps
`default_nettype none
module aife_top_props #(
  parameter int NCH = 8,
  parameter int BLINK_HALF = 4
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  input wire logic clkEn,
  // faults
  input wire logic hwFail,
  input wire logic calibBad,
  input wire logic supplyBad,
  input wire logic [NCH-1:0] rangeFault,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // indicators
  input wire logic runLamp,
  input wire logic errLamp,
  input wire logic [15:0] faultCode
);
  logic [1:0] upQ;
  logic lampQ;
  int stillQ;
  logic [NCH-1:0] r1Q;
  logic [NCH-1:0] r2Q;
  logic ok;
  // inputs before release are not trusted
  assign ok = upQ == 2'h3;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      upQ <= 2'h0;
      stillQ <= 0;
    end else begin
      if (upQ != 2'h3) upQ <= upQ + 2'h1;
      stillQ <= (faultCode[15:8] == 8'hA0 && errLamp == lampQ) ? stillQ + 1 : 0;
    end
  end
  always_ff @(posedge mclk) begin
    lampQ <= errLamp;
    r1Q <= rangeFault;
    r2Q <= r1Q;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence busReq;
    wb_cyc_i && wb_stb_i && !wb_ack_o && clkEn;
  endsequence
  sequence ackPulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  hw_code_a: assert property (
    ok && $past(hwFail, 2) |-> faultCode == 16'hA600) else $error("hw code");
  supply_code_a: assert property (
    ok && $past(supplyBad, 2) && !$past(hwFail, 2) |-> faultCode == 16'hA601)
    else $error("supply code");
  calib_code_a: assert property (
    ok && $past(calibBad, 2) && !$past(hwFail, 2) && !$past(supplyBad, 2)
    |-> faultCode == 16'hA603) else $error("calib code");
  alarm_lamps_a: assert property (
    faultCode[15:8] == 8'hA6 || faultCode[15:8] == 8'hA4 |-> !runLamp && errLamp)
    else $error("alarm lamps");
  quiet_lamps_a: assert property (
    faultCode[15:8] == 8'hA8 |-> runLamp && !errLamp) else $error("quiet lamps");
  blink_lamps_a: assert property (
    faultCode[15:8] == 8'hA0 |-> runLamp && stillQ <= BLINK_HALF) else $error("blink");
  chan_source_a: assert property (
    ok && faultCode[15:12] == 4'hA && faultCode[11:8] != 4'h6 && faultCode[11:8] != 4'h0
    |-> faultCode[7:3] == 5'h00 && r2Q[faultCode[2:0]]) else $error("channel code");
  bus_ack_a: assert property (busReq |=> ackPulse) else $error("ack timing");
endmodule : aife_top_props
bind aife_top aife_top_props #(.NCH(NCH), .BLINK_HALF(BLINK_HALF)) props (.mclk(mclk),
  .nrst(nrst), .clkEn(clkEn), .hwFail(hwFail), .calibBad(calibBad), .supplyBad(supplyBad),
  .rangeFault(rangeFault), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .runLamp(runLamp), .errLamp(errLamp), .faultCode(faultCode));
`default_nettype wire

// [verification/aife_top_test.sv]
/* aife_top_test: self-checking bench for aife_top.
   assumes aife_host as bus master and a short blink count. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin samplesChecked++; if ((a) !== (b)) begin errCount++; \
  $display("Error %0t: got %h exp %h", $time, (a), (b)); end end
module aife_top_test;
  localparam int HALF = 4;
  logic mclk, nrst, hwFail, calibBad, supplyBad, cyc, stb, we, ack, runLamp, errLamp, irq;
  logic clkEn;
  logic [7:0] rangeFault;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dout, din, q;
  logic [15:0] faultCode;
  int errCount;
  int samplesChecked;
  aife_top #(.NCH(8), .BLINK_HALF(HALF)) dut (.mclk(mclk), .nrst(nrst), .clkEn(clkEn),
    .hwFail(hwFail), .calibBad(calibBad), .supplyBad(supplyBad), .rangeFault(rangeFault),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dout), .wb_dat_o(din), .wb_ack_o(ack), .runLamp(runLamp), .errLamp(errLamp),
    .faultCode(faultCode), .irq(irq));
  aife_host host (.mclk(mclk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
    .dout(dout), .din(din), .ack(ack));
  task automatic summarize();
    if (errCount == 0 && samplesChecked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h0000_0000, q);
    `CHK(q, e)
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q);
  endtask
  // m is {hwFail, supplyBad, calibBad}
  task automatic setf(input logic [2:0] m, input logic [7:0] r);
    @(posedge mclk);
    {hwFail, supplyBad, calibBad} <= m;
    rangeFault <= r;
    repeat (4) @(posedge mclk);
  endtask
  task automatic resetVals();
    rd(aife_pkg::OFF_CONFIG, {16'h0000, aife_pkg::CONFIG_RST});
    rd(aife_pkg::OFF_LAMPCFG, {24'h00_0000, aife_pkg::LAMPCFG_RST});
    rd(aife_pkg::OFF_IRQMASK, {29'h0000_0000, aife_pkg::IRQMASK_RST});
    rd(8'h1C, 32'h0000_0000);
    `CHK({faultCode, runLamp, errLamp}, {16'h0000, 2'b10})
  endtask
  task automatic modAlarms();
    setf(3'b111, 8'h01);
    `CHK({faultCode, runLamp, errLamp}, {16'hA600, 2'b01})
    rd(aife_pkg::OFF_FLAGS, 32'h0000_8001);
    setf(3'b011, 8'h01);
    `CHK({faultCode, runLamp, errLamp}, {16'hA601, 2'b01})
    setf(3'b001, 8'h01);
    `CHK({faultCode, runLamp, errLamp}, {16'hA603, 2'b01})
    setf(3'b000, 8'h00);
  endtask
  task automatic chanClasses();
    logic [15:0] base [3];
    logic lv;
    int n;
    base = '{16'hA800, 16'hA000, 16'hA400};
    for (int ch = 0; ch < 8; ch++) begin
      for (int c = 0; c < 3; c++) begin
        wr(aife_pkg::OFF_CONFIG, c == 2 ? 32'h0000_0100 << ch : 32'h0000_0000);
        wr(aife_pkg::OFF_LAMPCFG, c == 1 ? 32'h0000_0001 << ch : 32'h0000_0000);
        setf(3'b000, 8'h01 << ch);
        `CHK(faultCode, base[c] | 16'(ch))
        rd(aife_pkg::OFF_FLAGS, 32'h0000_0001 << ch);
        lv = errLamp;
        n = 0;
        while (c == 1 && errLamp === lv && n < 2 * HALF + 2) begin
          @(posedge mclk);
          n++;
        end
        if (c == 1) `CHK({runLamp, errLamp !== lv}, 2'b11)
        else `CHK({runLamp, errLamp}, c == 2 ? 2'b01 : 2'b10)
      end
    end
    setf(3'b000, 8'h00);
  endtask
  task automatic prio();
    wr(aife_pkg::OFF_CONFIG, 32'h0000_6000);
    wr(aife_pkg::OFF_LAMPCFG, 32'h0000_0008);
    setf(3'b000, 8'hFF);
    `CHK(faultCode, 16'hA405)
    setf(3'b000, 8'h9C);
    `CHK(faultCode, 16'hA003)
    setf(3'b000, 8'h94);
    `CHK(faultCode, 16'hA802)
    setf(3'b010, 8'hFF);
    `CHK(faultCode, 16'hA601)
    setf(3'b000, 8'h00);
  endtask
  task automatic irqFlow();
    wr(aife_pkg::OFF_IRQMASK, 32'h0000_0001);
    wr(aife_pkg::OFF_IRQSTAT, 32'h0000_0007);
    wr(aife_pkg::OFF_CONFIG, 32'h0000_0100);
    `CHK(irq, 1'b0)
    setf(3'b000, 8'h01);
    `CHK(irq, 1'b1)
    rd(aife_pkg::OFF_IRQSTAT, 32'h0000_0005);
    // live alarm re-sets its bit over the clear
    wr(aife_pkg::OFF_IRQSTAT, 32'h0000_0001);
    rd(aife_pkg::OFF_IRQSTAT, 32'h0000_0005);
    wr(aife_pkg::OFF_IRQMASK, 32'h0000_0000);
    repeat (2) @(posedge mclk);
    `CHK(irq, 1'b0)
    wr(aife_pkg::OFF_IRQMASK, 32'h0000_0001);
    setf(3'b000, 8'h00);
    wr(aife_pkg::OFF_IRQSTAT, 32'h0000_0007);
    repeat (2) @(posedge mclk);
    `CHK(irq, 1'b0)
  endtask
  // enable low must hold code and lamps still
  task automatic freeze();
    @(posedge mclk);
    clkEn <= 1'b0;
    rangeFault <= 8'h01;
    repeat (6) @(posedge mclk);
    `CHK({faultCode, runLamp, errLamp}, {16'h0000, 2'b10})
    clkEn <= 1'b1;
    repeat (4) @(posedge mclk);
    `CHK({faultCode, runLamp, errLamp}, {16'hA400, 2'b01})
    setf(3'b000, 8'h00);
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    {nrst, hwFail, calibBad, supplyBad, rangeFault} = '0;
    clkEn = 1'b1;
    errCount = 0;
    samplesChecked = 0;
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    resetVals();
    modAlarms();
    chanClasses();
    prio();
    irqFlow();
    freeze();
    summarize();
  end
  // whole run is some hundreds of cycles
  initial begin
    #200us;
    errCount++;
    summarize();
  end
endmodule : aife_top_test
`default_nettype wire
